/* inc/fpe_pkg.sv */
// package: constants for the front panel parameter entry block
package fpe_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] FPE_MOTION_ADDR = 16'hFFA2;
  localparam logic [15:0] FPE_SWITCH_ADDR = 16'hFFA3;
  // ==========================================================
  // motion status field positions
  localparam int FPE_BIT_SRC = 7;
  localparam int FPE_BIT_MOVE = 6;
  localparam int FPE_BIT_OVR = 5;
  localparam int FPE_BIT_DIR = 4;
  // ==========================================================
  // reset values
  localparam logic [7:0] FPE_LAMP_RST = 8'h00;
  localparam logic [7:0] FPE_SWITCH_RST = 8'h00;
  localparam logic [7:0] FPE_RDATA_RST = 8'h00;
  // ==========================================================
  // debounce timing
  localparam int unsigned FPE_DEBOUNCE_MS = 25;
  localparam int unsigned FPE_CLK_KHZ = 25000;
  localparam int unsigned FPE_DEBOUNCE_CYC = FPE_DEBOUNCE_MS * FPE_CLK_KHZ;
  localparam int FPE_CNT_W = 20;
  // ==========================================================
  // one-shot timer states, gray coded along idle -> run -> done
  typedef enum logic [1:0] {
    FPE_ST_IDLE = 2'b00,
    FPE_ST_RUN = 2'b01,
    FPE_ST_DONE = 2'b11
  } fpe_tmr_state_t;
endpackage : fpe_pkg

/* inc/fpe_dbnc_if.sv */
// interface: handshake between the entry logic and its one-shot timer
`timescale 1ns/10ps
interface fpe_dbnc_if;
  logic start;
  logic busy;
  logic expire;
  modport timer (input start, output busy, output expire);
  modport user (output start, input busy, input expire);
endinterface : fpe_dbnc_if

/* rtl/fpe_oneshot.sv */
// module: retriggerless one-shot timer used for switch debounce
`timescale 1ns/10ps
module fpe_oneshot
  import fpe_pkg::*;
#(
  parameter int CNT_W = FPE_CNT_W,
  parameter int unsigned CYCLES = FPE_DEBOUNCE_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  fpe_dbnc_if.timer tmr
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  fpe_tmr_state_t state_r;
  logic [CNT_W-1:0] cnt_r;

  // ==========================================================
  // state and count; a start while running is ignored
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= FPE_ST_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        FPE_ST_IDLE: begin
          cnt_r <= '0;
          if (tmr.start) begin
            state_r <= FPE_ST_RUN;
          end
        end
        FPE_ST_RUN: begin
          if (cnt_r == LAST) begin
            state_r <= FPE_ST_DONE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        FPE_ST_DONE: state_r <= FPE_ST_IDLE;
        default: state_r <= FPE_ST_IDLE;
      endcase
    end
  end

  assign tmr.busy = (state_r != FPE_ST_IDLE);
  assign tmr.expire = (state_r == FPE_ST_DONE);

  // ==========================================================
  // checks
  logic [CNT_W:0] span_r;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      span_r <= '0;
    end else if (state_r == FPE_ST_RUN) begin
      span_r <= span_r + 1'b1;
    end else begin
      span_r <= '0;
    end
  end

  a_oneshot_length: assert property (
    @(posedge clock_i) disable iff (!nrst_i)
    tmr.expire |-> span_r == (CNT_W+1)'(CYCLES))
    else $error("one-shot expired at the wrong count");
endmodule : fpe_oneshot

/* rtl/fpe_panel.sv */
// module: front panel switch, lamp and card motion entry logic
//
// Functional notes
// - debounce switches with 25 ms one-shot
// - debounce expiry with a newly pressed switch raises the panel interrupt
// - read at switch address returns switch states
// - write at switch address loads lamp register
// - lamp bit one lights, zero darkens
// - rising track A means card moved in
// - falling track B means card moved out
// - card motion raises same panel interrupt
// - motion read returns motion status byte
// - status bit 7 marks block as source
// - status bit 6 marks motion, not switch
// - status bit 5 reports motion overrun
// - status bit 4 gives direction, one out
// - reset lights the init lamp
// - init lamp lit suppresses all interrupts
// - track C home clears lamp, enables detection
// - motion while still pending sets overrun
//
// presses made before homing are dropped rather than queued, so
// the first interrupt after homing always reflects a fresh event
// a motion read in the same cycle as a new move reports no overrun
`timescale 1ns/10ps
module fpe_panel
  import fpe_pkg::*;
#(
  parameter int CNT_W = FPE_CNT_W,
  parameter int unsigned DEBOUNCE_CYC = FPE_DEBOUNCE_CYC,
  parameter int NSW = 8
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [15:0] bus_addr_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [NSW-1:0] switch_i,
  input wire logic track_a_i,
  input wire logic track_b_i,
  input wire logic track_c_i,
  output logic [7:0] bus_rdata_o,
  output logic bus_rdata_valid_o,
  output logic [NSW-1:0] lamp_o,
  output logic init_lamp_on_n_o,
  output logic panel_irq_req_o
);

  // ==========================================================
  // address decode
  function automatic logic addr_hit(input logic [15:0] a,
                                    input logic [15:0] base);
    addr_hit = (a == base);
  endfunction : addr_hit

  logic switch_read_en_n;
  logic lamp_write_en_n;
  logic motion_read_en_n;

  // strobes kept active low as on the panel board
  assign switch_read_en_n = !(bus_rd_i && addr_hit(bus_addr_i,
                              FPE_SWITCH_ADDR));
  assign motion_read_en_n = !(bus_rd_i && addr_hit(bus_addr_i,
                              FPE_MOTION_ADDR));
  assign lamp_write_en_n = !(bus_wr_i && addr_hit(bus_addr_i,
                             FPE_SWITCH_ADDR));

  // ==========================================================
  // initialization interlock
  logic init_done_r;

  // the lamp is lit from reset until the card reaches home
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_done_r <= 1'b0;
    end else if (track_c_i) begin
      init_done_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      init_lamp_on_n_o <= 1'b0;
    end else begin
      init_lamp_on_n_o <= init_done_r;
    end
  end

  // ==========================================================
  // switch debounce
  fpe_dbnc_if dbnc ();

  fpe_oneshot #(
    .CNT_W(CNT_W),
    .CYCLES(DEBOUNCE_CYC)
  ) i_fpe_oneshot (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .tmr(dbnc.timer)
  );

  logic [NSW-1:0] sw_stable_r;
  logic [NSW-1:0] sw_new_press;
  logic sw_event;

  // a change arms the timer; the level is only trusted when it expires
  assign dbnc.start = (switch_i != sw_stable_r) && !dbnc.busy;
  assign sw_new_press = switch_i & ~sw_stable_r;
  // presses during init are absorbed so no stale irq after release
  assign sw_event = dbnc.expire && (|sw_new_press) && init_done_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_stable_r <= FPE_SWITCH_RST;
    end else if (dbnc.expire) begin
      sw_stable_r <= switch_i;
    end
  end

  // ==========================================================
  // quadrature motion detector
  logic trk_a_prev_r;
  logic trk_b_prev_r;
  logic move_in;
  logic move_out;
  logic move_evt;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trk_a_prev_r <= 1'b0;
      trk_b_prev_r <= 1'b0;
    end else begin
      trk_a_prev_r <= track_a_i;
      trk_b_prev_r <= track_b_i;
    end
  end

  // detector held off until the card has been homed
  assign move_in = init_done_r && track_a_i && !trk_a_prev_r;
  assign move_out = init_done_r && !track_b_i && trk_b_prev_r;
  assign move_evt = move_in || move_out;

  // ==========================================================
  // pending flags; a new event beats a same-cycle clear, except that a motion read clears overrun
  logic sw_pend_r;
  logic mv_pend_r;
  logic ovr_r;
  logic dir_out_r;

  // switch flag cleared by reading the switch register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_pend_r <= 1'b0;
    end else if (sw_event) begin
      sw_pend_r <= 1'b1;
    end else if (!switch_read_en_n) begin
      sw_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mv_pend_r <= 1'b0;
    end else if (move_evt) begin
      mv_pend_r <= 1'b1;
    end else if (!motion_read_en_n) begin
      mv_pend_r <= 1'b0;
    end
  end

  // overrun only when the earlier report is still unread
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovr_r <= 1'b0;
    end else if (move_evt && mv_pend_r && motion_read_en_n) begin
      ovr_r <= 1'b1;
    end else if (!motion_read_en_n) begin
      ovr_r <= 1'b0;
    end
  end

  // outward wins if both tracks fire in one cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_out_r <= 1'b0;
    end else if (move_evt) begin
      dir_out_r <= move_out;
    end
  end

  // ==========================================================
  // interrupt request
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      panel_irq_req_o <= 1'b0;
    end else begin
      panel_irq_req_o <= (sw_pend_r || mv_pend_r) && init_done_r;
    end
  end

  // ==========================================================
  // lamp register, write only
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lamp_o <= FPE_LAMP_RST;
    end else if (!lamp_write_en_n) begin
      lamp_o <= bus_wdata_i[NSW-1:0];
    end
  end

  // ==========================================================
  // read data; unmapped reads return zero with no valid
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[FPE_BIT_SRC] = sw_pend_r || mv_pend_r;
    status_byte[FPE_BIT_MOVE] = mv_pend_r;
    status_byte[FPE_BIT_OVR] = ovr_r;
    status_byte[FPE_BIT_DIR] = dir_out_r;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_rdata_o <= FPE_RDATA_RST;
      bus_rdata_valid_o <= 1'b0;
    end else begin
      bus_rdata_valid_o <= !switch_read_en_n || !motion_read_en_n;
      if (!switch_read_en_n) begin
        bus_rdata_o <= 8'(sw_stable_r);
      end else if (!motion_read_en_n) begin
        bus_rdata_o <= status_byte;
      end else if (bus_rd_i) begin
        bus_rdata_o <= FPE_RDATA_RST;
      end
    end
  end

  // ==========================================================
  // checks
  // every check runs on the system clock and sleeps during reset
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_irq_suppress: assert property (
    !init_lamp_on_n_o |-> !panel_irq_req_o)
    else $error("interrupt raised while init lamp lit");

  a_home_release: assert property (
    !init_done_r && track_c_i |=> init_done_r ##1 init_lamp_on_n_o)
    else $error("home position did not clear init lamp");

  a_move_inward: assert property (
    init_done_r && $rose(track_a_i) && !$fell(track_b_i)
    |=> mv_pend_r && !dir_out_r)
    else $error("inward motion not reported");

  a_move_outward: assert property (
    init_done_r && $fell(track_b_i) |=> mv_pend_r && dir_out_r)
    else $error("outward motion not reported");

  a_overrun_set: assert property (
    move_evt && mv_pend_r && motion_read_en_n |=> ovr_r)
    else $error("overrun not flagged");

  a_motion_clear: assert property (
    !motion_read_en_n && !move_evt |=> !mv_pend_r && !ovr_r)
    else $error("motion read did not clear flags");

  a_irq_raise: assert property (
    init_done_r && (sw_pend_r || mv_pend_r) |=> panel_irq_req_o)
    else $error("pending event gave no interrupt");

  a_lamp_load: assert property (
    !lamp_write_en_n |=> lamp_o == $past(bus_wdata_i[NSW-1:0]))
    else $error("lamp register not loaded");

  a_switch_read: assert property (
    !switch_read_en_n |=> bus_rdata_valid_o &&
    bus_rdata_o == $past(8'(sw_stable_r)))
    else $error("switch read data wrong");

  a_status_read: assert property (
    !motion_read_en_n |=> bus_rdata_o[7:4] ==
    $past({sw_pend_r || mv_pend_r, mv_pend_r, ovr_r, dir_out_r}))
    else $error("motion status read wrong");

  a_switch_event: assert property (
    sw_event && !move_evt && !mv_pend_r |=> sw_pend_r && !mv_pend_r)
    else $error("switch press flagged as motion");

  // ==========================================================
  // checks on flag history and refused accesses
  a_lamp_hold: assert property (
    lamp_write_en_n |=> $stable(lamp_o))
    else $error("lamp register changed without a write");

  a_unmapped_read: assert property (
    bus_rd_i && switch_read_en_n && motion_read_en_n
    |=> !bus_rdata_valid_o && bus_rdata_o == FPE_RDATA_RST)
    else $error("unmapped read answered");

  a_status_source: assert property (
    !motion_read_en_n && (sw_pend_r || mv_pend_r)
    |=> bus_rdata_o[FPE_BIT_SRC])
    else $error("source bit clear with event pending");

  a_overrun_report: assert property (
    !motion_read_en_n |=> bus_rdata_o[FPE_BIT_OVR] == $past(ovr_r))
    else $error("overrun bit misreported");

  a_overrun_cause: assert property (
    $rose(ovr_r) |-> $past(mv_pend_r) && $past(move_evt))
    else $error("overrun raised without a second move");

  a_dir_hold: assert property (
    !move_evt |=> $stable(dir_out_r))
    else $error("direction changed without motion");

  a_lamp_while_init: assert property (
    !init_done_r |-> !init_lamp_on_n_o)
    else $error("init lamp dark before homing");

  a_flags_gated: assert property (
    !init_done_r |-> !sw_pend_r && !mv_pend_r)
    else $error("event latched before homing");

  a_irq_cause: assert property (
    panel_irq_req_o |-> $past(sw_pend_r || mv_pend_r))
    else $error("interrupt without a pending event");

  a_press_at_expiry: assert property (
    $rose(sw_pend_r) |-> $past(dbnc.expire))
    else $error("switch event outside debounce expiry");

  a_switch_clear: assert property (
    !switch_read_en_n && !sw_event |=> !sw_pend_r)
    else $error("switch read did not clear its flag");

  // scenarios worth seeing in a run
  c_switch_irq: cover property (sw_event ##[1:4] panel_irq_req_o);
  c_move_out: cover property (move_out ##2 panel_irq_req_o);
  c_overrun: cover property (move_evt && mv_pend_r);
  c_home: cover property ($rose(init_done_r));
  c_lamp_write: cover property (!lamp_write_en_n);
endmodule : fpe_panel

/* verification/fpe_panel_model.sv */
// partner model: panel pushbuttons and the card's three optical tracks
`timescale 1ns/10ps
module fpe_panel_model (
  input wire logic clock_i,
  output logic [7:0] switch_o,
  output logic track_a_o,
  output logic track_b_o,
  output logic track_c_o
);
  // ==========================================================
  // card away from home; buttons released
  initial begin
    switch_o = 8'h00;
    track_a_o = 1'b0;
    track_b_o = 1'b1;
    track_c_o = 1'b0;
  end
  // buttons hold a level; bounce filtering is the block's job
  task automatic press(input logic [7:0] v);
    @(negedge clock_i);
    switch_o = v;
  endtask : press
  // each move first drives the track to the start level of its motion edge; reaching that level is not motion
  task automatic move(input logic out);
    @(negedge clock_i);
    if (out) begin
      track_b_o = 1'b1;
      @(negedge clock_i);
      track_b_o = 1'b0;
    end else begin
      track_a_o = 1'b0;
      @(negedge clock_i);
      track_a_o = 1'b1;
    end
  endtask : move
  // card fully inserted: light reaches track C and stays there
  task automatic home();
    @(negedge clock_i);
    track_c_o = 1'b1;
  endtask : home
endmodule : fpe_panel_model

/* verification/fpe_panel_tb.sv */
// testbench: register access, card motion, debounce and init interlock
`timescale 1ns/10ps
module fpe_panel_tb;
  import fpe_pkg::*;
  // short debounce keeps the run brief
  localparam int unsigned DEB = 8;
  localparam logic [7:0] SRC = 8'h01 << FPE_BIT_SRC;
  localparam logic [7:0] MOV = 8'h01 << FPE_BIT_MOVE;
  localparam logic [7:0] OVR = 8'h01 << FPE_BIT_OVR;
  localparam logic [7:0] DIR = 8'h01 << FPE_BIT_DIR;
  logic clock_i;
  logic nrst_i;
  logic [15:0] bus_addr_i;
  logic bus_rd_i;
  logic bus_wr_i;
  logic [7:0] bus_wdata_i;
  logic [7:0] switch_i;
  logic track_a_i;
  logic track_b_i;
  logic track_c_i;
  logic [7:0] bus_rdata_o;
  logic [7:0] lamp_o;
  logic bus_rdata_valid_o;
  logic init_lamp_on_n_o;
  logic panel_irq_req_o;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ==========================================================
  // instances
  fpe_panel #(.DEBOUNCE_CYC(DEB)) i_fpe_panel (
    .clock_i(clock_i), .nrst_i(nrst_i), .bus_addr_i(bus_addr_i),
    .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i),
    .switch_i(switch_i), .track_a_i(track_a_i), .track_b_i(track_b_i),
    .track_c_i(track_c_i), .bus_rdata_o(bus_rdata_o),
    .bus_rdata_valid_o(bus_rdata_valid_o), .lamp_o(lamp_o),
    .init_lamp_on_n_o(init_lamp_on_n_o), .panel_irq_req_o(panel_irq_req_o)
  );
  fpe_panel_model i_fpe_panel_model (
    .clock_i(clock_i), .switch_o(switch_i), .track_a_o(track_a_i),
    .track_b_o(track_b_i), .track_c_o(track_c_i)
  );
  // ==========================================================
  // clock and hang guard
  always #20 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("CHECK FAILED run length expected 3000 seen %0d", cycles);
      results();
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // strobe is a one-cycle pulse; the answer stands right after its edge
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
                        input logic ev);
    @(negedge clock_i);
    bus_addr_i = a;
    bus_rd_i = 1'b1;
    @(negedge clock_i);
    bus_rd_i = 1'b0;
    chk("rdata", e, bus_rdata_o);
    chk("rdata_valid", {7'h00, ev}, {7'h00, bus_rdata_valid_o});
  endtask : rd_chk
  // write then let the lamp register settle before looking
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    bus_addr_i = a;
    bus_wdata_i = d;
    bus_wr_i = 1'b1;
    @(negedge clock_i);
    bus_wr_i = 1'b0;
    @(negedge clock_i);
  endtask : wr
  // bounded wait for the request line to reach a level
  task automatic irq(input int n, input logic e);
    for (int i = 0; i < n && panel_irq_req_o !== e; i++) begin
      @(negedge clock_i);
    end
    chk("panel_irq_req", {7'h00, e}, {7'h00, panel_irq_req_o});
  endtask : irq
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // ==========================================================
  // main sequence
  initial begin
    clock_i = 1'b0;
    nrst_i = 1'b0;
    bus_addr_i = 16'h0000;
    bus_rd_i = 1'b0;
    bus_wr_i = 1'b0;
    bus_wdata_i = 8'h00;
    repeat (2) @(negedge clock_i);
    nrst_i = 1'b1;
    chk("init_lamp_on_n", 8'h00, {7'h00, init_lamp_on_n_o});
    chk("lamp", FPE_LAMP_RST, lamp_o);
    irq(0, 1'b0);
    // activity before home must stay silent
    i_fpe_panel_model.press(8'h10);
    i_fpe_panel_model.move(1'b0);
    i_fpe_panel_model.move(1'b1);
    repeat (DEB + 6) @(negedge clock_i);
    irq(0, 1'b0);
    rd_chk(FPE_MOTION_ADDR, 8'h00, 1'b1);
    i_fpe_panel_model.press(8'h00);
    repeat (DEB + 6) @(negedge clock_i);
    i_fpe_panel_model.home();
    repeat (3) @(negedge clock_i);
    chk("init_lamp_on_n", 8'h01, {7'h00, init_lamp_on_n_o});
    irq(0, 1'b0);
    $display("test interlock done");
    // lamp register: write only, one bit per lamp
    wr(FPE_SWITCH_ADDR, 8'hA5);
    chk("lamp", 8'hA5, lamp_o);
    wr(FPE_SWITCH_ADDR, 8'h5A);
    chk("lamp", 8'h5A, lamp_o);
    wr(FPE_MOTION_ADDR, 8'hFF);
    wr(16'hFFA4, 8'hFF);
    chk("lamp", 8'h5A, lamp_o);
    rd_chk(FPE_SWITCH_ADDR, 8'h00, 1'b1);
    rd_chk(16'hFFA1, 8'h00, 1'b0);
    $display("test registers done");
    // card motion, direction, overrun and clearing by read
    i_fpe_panel_model.move(1'b0);
    irq(4, 1'b1);
    rd_chk(FPE_MOTION_ADDR, SRC | MOV, 1'b1);
    irq(3, 1'b0);
    i_fpe_panel_model.move(1'b1);
    irq(4, 1'b1);
    rd_chk(FPE_MOTION_ADDR, SRC | MOV | DIR, 1'b1);
    i_fpe_panel_model.move(1'b1);
    i_fpe_panel_model.move(1'b1);
    irq(4, 1'b1);
    rd_chk(FPE_MOTION_ADDR, SRC | MOV | OVR | DIR, 1'b1);
    rd_chk(FPE_MOTION_ADDR, DIR, 1'b1);
    irq(3, 1'b0);
    $display("test motion done");
    // switch press: no request before the one-shot ends
    i_fpe_panel_model.press(8'h81);
    repeat (DEB) @(negedge clock_i);
    irq(0, 1'b0);
    irq(8, 1'b1);
    rd_chk(FPE_MOTION_ADDR, SRC | DIR, 1'b1);
    rd_chk(FPE_SWITCH_ADDR, 8'h81, 1'b1);
    irq(3, 1'b0);
    i_fpe_panel_model.press(8'h00);
    repeat (DEB + 6) @(negedge clock_i);
    irq(0, 1'b0);
    rd_chk(FPE_SWITCH_ADDR, 8'h00, 1'b1);
    $display("test switches done");
    results();
  end
endmodule : fpe_panel_tb
